// ==== hw/analog_select_bit_pkg.sv ====
package analog_select_bit_pkg;

  // Pin count of one port and number of change notification inputs.
  localparam int ANALOG_SELECT_BIT_PORT_WIDTH = 16;
  localparam int ANALOG_SELECT_BIT_CN_COUNT = 24;
  localparam int ANALOG_SELECT_BIT_CN_LO_WIDTH = 16;
  localparam int ANALOG_SELECT_BIT_CN_HI_WIDTH = ANALOG_SELECT_BIT_CN_COUNT - ANALOG_SELECT_BIT_CN_LO_WIDTH;

  // Values after reset.
  localparam logic [15:0] ANALOG_SELECT_BIT_DIR_RESET = 16'hffff;
  localparam logic [15:0] ANALOG_SELECT_BIT_LATCH_RESET = 16'h0000;
  localparam logic [15:0] ANALOG_SELECT_BIT_OD_RESET = 16'h0000;
  localparam logic [15:0] ANALOG_SELECT_BIT_ANA_RESET = 16'h0000;
  localparam logic [15:0] ANALOG_SELECT_BIT_CN_EN_RESET = 16'h0000;
  localparam logic [15:0] ANALOG_SELECT_BIT_PU_EN_RESET = 16'h0000;

  // Cycles a read waits after an output latch write or direction change to the same port.
  localparam int ANALOG_SELECT_BIT_READ_SETTLE_CYCLES = 1;

endpackage

// ==== hw/analog_select_bit_port.sv ====
`timescale 1ns/1ps
// Summary of operation
// - Per-pin open-drain select: set gives open-drain, clear gives push-pull drive.
// - Clearing a pin's analog select bit makes it analog; it stays digital only when set in both configs.
// - Analog select bits reset cleared, so analog-capable pins start analog.
// - A pin is analog when its bit is cleared in either converter's config.
// - Port reads return zero for every pin configured as analog input.
// - A port read needs one cycle after an output latch write or direction change.
// - Any enabled input changing in either direction raises the change request.
// - Change detection works in sleep only while clk keeps running; sleep_mode is not used.
// - Up to 24 change inputs, numbered from zero.
// - Each change input has its own enable bit across two enable words.
// - Each change pin has a weak pull-up enabled by its own bit.

module analog_select_bit_port #(
  parameter int PORT_WIDTH = analog_select_bit_pkg::ANALOG_SELECT_BIT_PORT_WIDTH,
  parameter int CN_COUNT = analog_select_bit_pkg::ANALOG_SELECT_BIT_CN_COUNT
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Register writes from the processor, one strobe per register.
  input wire logic [PORT_WIDTH-1:0] wr_data,
  input wire logic wr_direction_select,
  input wire logic wr_output_latch,
  input wire logic wr_open_drain_select,
  input wire logic wr_analog_pin_config_low,
  input wire logic wr_analog_pin_config_low2,
  input wire logic [CN_COUNT-1:0] wr_change_irq_enable,
  input wire logic wr_change_irq_enable_lo,
  input wire logic wr_change_irq_enable_hi,
  input wire logic wr_weak_pullup_enable_lo,
  input wire logic wr_weak_pullup_enable_hi,
  // Port read request.
  input wire logic rd_port,
  // Sleep mode indication.
  input wire logic sleep_mode,
  // Pins and change notification inputs.
  input wire logic [PORT_WIDTH-1:0] pin_in,
  input wire logic [CN_COUNT-1:0] change_notify_input,
  // Pin drive.
  output logic [PORT_WIDTH-1:0] pin_out,
  output logic [PORT_WIDTH-1:0] pin_oe_n,
  output logic [PORT_WIDTH-1:0] analog_mode,
  output logic [CN_COUNT-1:0] weak_pullup_on,
  // Read data and status.
  output logic [PORT_WIDTH-1:0] rd_data,
  output logic rd_valid,
  output logic change_irq,
  // Register read-back.
  output logic [PORT_WIDTH-1:0] direction_select,
  output logic [PORT_WIDTH-1:0] output_latch,
  output logic [PORT_WIDTH-1:0] open_drain_select,
  output logic [CN_COUNT-1:0] change_irq_enable_bit
);

  initial
  begin
    if (PORT_WIDTH < 1 || PORT_WIDTH > 16 || CN_COUNT < 1 || CN_COUNT > 24)
      $error("analog_select_bit_port: unsupported width");
  end

  //////////////////////////////////////////////////////////////////////////////
  logic [PORT_WIDTH-1:0] analog_pin_config_low_ff;
  logic [PORT_WIDTH-1:0] analog_pin_config_low2_ff;
  logic [CN_COUNT-1:0] weak_pullup_enable_bit_ff;
  logic [CN_COUNT-1:0] cn_sync1_ff;
  logic [CN_COUNT-1:0] cn_sync2_ff;
  logic [CN_COUNT-1:0] cn_prev_ff;
  logic [PORT_WIDTH-1:0] pin_sync1_ff;
  logic [PORT_WIDTH-1:0] pin_sync2_ff;
  logic settle_ff;
  logic [PORT_WIDTH-1:0] nxt_analog;
  logic [CN_COUNT-1:0] nxt_change;
  logic [CN_COUNT-1:0] pu_mask_lo;
  logic [CN_COUNT-1:0] pu_mask_hi;

  // Low sixteen and high remaining bits of the split change words.
  assign pu_mask_lo = CN_COUNT'((1 << ((CN_COUNT < 16) ? CN_COUNT : 16)) - 1);
  assign pu_mask_hi = ~pu_mask_lo;

  // Direction, latch and open-drain configuration words.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      direction_select <= PORT_WIDTH'(analog_select_bit_pkg::ANALOG_SELECT_BIT_DIR_RESET);
      output_latch <= PORT_WIDTH'(analog_select_bit_pkg::ANALOG_SELECT_BIT_LATCH_RESET);
      open_drain_select <= PORT_WIDTH'(analog_select_bit_pkg::ANALOG_SELECT_BIT_OD_RESET);
    end
    else
    begin
      if (wr_direction_select)
        direction_select <= wr_data;
      if (wr_output_latch)
        output_latch <= wr_data;
      if (wr_open_drain_select)
        open_drain_select <= wr_data;
    end
  end

  // Analog configuration words of both converters.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      analog_pin_config_low_ff <= PORT_WIDTH'(analog_select_bit_pkg::ANALOG_SELECT_BIT_ANA_RESET);
      analog_pin_config_low2_ff <= PORT_WIDTH'(analog_select_bit_pkg::ANALOG_SELECT_BIT_ANA_RESET);
    end
    else
    begin
      if (wr_analog_pin_config_low)
        analog_pin_config_low_ff <= wr_data;
      if (wr_analog_pin_config_low2)
        analog_pin_config_low2_ff <= wr_data;
    end
  end

  always_comb
  begin
    nxt_analog = ~analog_pin_config_low_ff | ~analog_pin_config_low2_ff;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin drive. Open-drain pins only pull low; a high latch releases the pin.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_out <= '0;
      pin_oe_n <= '1;
      analog_mode <= '1;
    end
    else
    begin
      pin_out <= output_latch & ~open_drain_select;
      pin_oe_n <= direction_select | (open_drain_select & output_latch);
      analog_mode <= nxt_analog;
    end
  end

  // Pin input synchronisers.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_sync1_ff <= '0;
      pin_sync2_ff <= '0;
    end
    else
    begin
      pin_sync1_ff <= pin_in;
      pin_sync2_ff <= pin_sync1_ff;
    end
  end

  // Read path. A read right after a latch or direction write still answers but is flagged invalid.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      settle_ff <= 1'b0;
      rd_data <= '0;
      rd_valid <= 1'b0;
    end
    else
    begin
      settle_ff <= wr_direction_select | wr_output_latch;
      rd_valid <= 1'b0;
      if (rd_port)
      begin
        rd_data <= pin_sync2_ff & ~nxt_analog;
        rd_valid <= ~settle_ff & ~wr_direction_select & ~wr_output_latch;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Change enable and pull-up words, each split into low sixteen and high remaining bits.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      change_irq_enable_bit <= CN_COUNT'(analog_select_bit_pkg::ANALOG_SELECT_BIT_CN_EN_RESET);
      weak_pullup_enable_bit_ff <= CN_COUNT'(analog_select_bit_pkg::ANALOG_SELECT_BIT_PU_EN_RESET);
    end
    else
    begin
      if (wr_change_irq_enable_lo)
        change_irq_enable_bit <= (change_irq_enable_bit & pu_mask_hi) | (wr_change_irq_enable & pu_mask_lo);
      else if (wr_change_irq_enable_hi)
        change_irq_enable_bit <= (change_irq_enable_bit & pu_mask_lo) | (wr_change_irq_enable & pu_mask_hi);
      if (wr_weak_pullup_enable_lo)
        weak_pullup_enable_bit_ff <= (weak_pullup_enable_bit_ff & pu_mask_hi) | (wr_change_irq_enable & pu_mask_lo);
      else if (wr_weak_pullup_enable_hi)
        weak_pullup_enable_bit_ff <= (weak_pullup_enable_bit_ff & pu_mask_lo) | (wr_change_irq_enable & pu_mask_hi);
    end
  end

  // Pull-up drive. Software keeps it off on pins driven as outputs.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      weak_pullup_on <= '0;
    else
      weak_pullup_on <= weak_pullup_enable_bit_ff;
  end

  // Twenty-four change inputs
  // Change inputs are synchronised; the second stage feeds the comparison.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cn_sync1_ff <= '0;
      cn_sync2_ff <= '0;
      cn_prev_ff <= '0;
    end
    else
    begin
      cn_sync1_ff <= change_notify_input;
      cn_sync2_ff <= cn_sync1_ff;
      cn_prev_ff <= cn_sync2_ff;
    end
  end

  always_comb
  begin
    nxt_change = (cn_sync2_ff ^ cn_prev_ff) & change_irq_enable_bit;
  end

  // Sleep only gates the core clock; this block is fed a clock kept alive in sleep.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      change_irq <= 1'b0;
    else
      change_irq <= |nxt_change;
  end

endmodule

// ==== dv/analog_select_bit_port_props.sv ====
`timescale 1ns/1ps
// Timing and masking relations seen at the port block's pins.
module analog_select_bit_port_props (
  // Clock, reset and requests.
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wr_direction_select,
  input wire logic wr_output_latch,
  input wire logic wr_weak_pullup_enable_lo,
  input wire logic [23:0] wr_change_irq_enable,
  input wire logic rd_port,
  input wire logic [23:0] change_notify_input,
  // Outputs under watch.
  input wire logic [15:0] pin_oe_n,
  input wire logic [15:0] analog_mode,
  input wire logic [23:0] weak_pullup_on,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  input wire logic change_irq,
  input wire logic [15:0] direction_select,
  input wire logic [15:0] output_latch,
  input wire logic [15:0] open_drain_select,
  input wire logic [23:0] change_irq_enable_bit
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////////
  // The change window is two to four edges wide because inputs pass two sync flops.
  property p_od; 1 |=> pin_oe_n == $past(direction_select | (open_drain_select & output_latch)); endproperty
  a_od: assert property (p_od) else $error("drive enable wrong");
  property p_rst; $rose(reset_n) |-> analog_mode == 16'hffff && direction_select == 16'hffff; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_zero; rd_valid |-> (rd_data & analog_mode & $past(analog_mode)) == 16'h0000; endproperty
  a_zero: assert property (p_zero) else $error("analog pin read nonzero");
  property p_refuse; rd_port && (wr_direction_select || wr_output_latch) |=> !rd_valid; endproperty
  a_refuse: assert property (p_refuse) else $error("early read marked valid");
  property p_valid; rd_port && !wr_output_latch && !$past(wr_output_latch) && !wr_direction_select
    && !$past(wr_direction_select) |=> rd_valid; endproperty
  a_valid: assert property (p_valid) else $error("settled read not valid");
  property p_chg; ((change_notify_input ^ $past(change_notify_input)) & change_irq_enable_bit) != 24'h0 |-> ##[2:4] change_irq; endproperty
  a_chg: assert property (p_chg) else $error("change missed");
  property p_en; change_irq |-> $past(change_irq_enable_bit) != 24'h0; endproperty
  a_en: assert property (p_en) else $error("change request with no enable");
  // The pull-up drive is registered once more behind the enable word, so it shows two edges on.
  property p_pu; wr_weak_pullup_enable_lo |=> ##1 weak_pullup_on[15:0] == $past(wr_change_irq_enable[15:0], 2);
  endproperty
  a_pu: assert property (p_pu) else $error("pull-up word wrong");
endmodule

// ==== dv/analog_select_bit_pins_model.sv ====
`timescale 1ns/1ps
// Board around the port: a released pin follows the outside driver.
module analog_select_bit_pins_model (
  // Block side and outside world.
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe_n,
  input wire logic [15:0] ext_level,
  output logic [15:0] pin_in
);
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_level);
endmodule

// ==== dv/analog_select_bit_port_test.sv ====
`timescale 1ns/1ps
module analog_select_bit_port_test;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic rd_port = 1'b0;
  logic sleep_mode = 1'b0;
  logic [8:0] stb = 9'h000;
  logic [23:0] wr_change_irq_enable = 24'h000000;
  logic [23:0] change_notify_input = 24'h000000;
  logic [15:0] ext = 16'h0000;
  logic wr_direction_select, wr_output_latch, wr_open_drain_select, wr_analog_pin_config_low;
  logic wr_analog_pin_config_low2, wr_change_irq_enable_lo, wr_change_irq_enable_hi;
  logic wr_weak_pullup_enable_lo, wr_weak_pullup_enable_hi, rd_valid, change_irq;
  logic [15:0] wr_data, pin_in, pin_out, pin_oe_n, analog_mode, rd_data;
  logic [15:0] direction_select, output_latch, open_drain_select;
  logic [23:0] weak_pullup_on, change_irq_enable_bit;
  int n_fail = 0;
  int samples_checked = 0;
  // One data word feeds every register; one strobe bit per register.
  assign wr_data = wr_change_irq_enable[15:0];
  assign {wr_weak_pullup_enable_hi, wr_weak_pullup_enable_lo, wr_change_irq_enable_hi, wr_change_irq_enable_lo,
    wr_analog_pin_config_low2, wr_analog_pin_config_low, wr_open_drain_select, wr_output_latch,
    wr_direction_select} = stb;
  analog_select_bit_port dut (.*);
  analog_select_bit_pins_model pins (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_level(ext), .pin_in(pin_in));
  initial forever #50 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    if (n_fail == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // A one-cycle strobe after one idle edge; the task returns as soon as the strobe drops.
  task automatic wr(input int k, input logic [23:0] d);
    @(posedge clk);
    #5 stb[k] = 1'b1;
    wr_change_irq_enable = d;
    @(posedge clk);
    #5 stb = 9'h000;
  endtask
  task automatic rd_chk(input logic [15:0] exp);
    @(posedge clk);
    #5 rd_port = 1'b1;
    @(posedge clk);
    #5 rd_port = 1'b0;
    chk(rd_valid, 1'b1);
    chk(rd_data, exp);
  endtask
  // Flips one change input and watches a bounded window for the request.
  task automatic cn_flip(input int b, input logic exp);
    logic seen;
    seen = 1'b0;
    @(posedge clk);
    #5 change_notify_input[b] = ~change_notify_input[b];
    repeat (6)
    begin
      @(posedge clk);
      #5 if (change_irq === 1'b1) seen = 1'b1;
    end
    chk(seen, exp);
    if (seen !== exp) finish_test();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge clk);
    #5 reset_n = 1'b1;
    chk(analog_mode, 16'hffff);
    chk(pin_oe_n, 16'hffff);
    wr(3, 24'h00ffff);
    wr(4, 24'h00ffff);
    ext = 16'ha5c3;
    repeat (3) @(posedge clk);
    rd_chk(16'ha5c3);
    wr(3, 24'h00ff00);
    repeat (2) @(posedge clk);
    chk(analog_mode, 16'h00ff);
    rd_chk(16'ha500);
    wr(3, 24'h00ffff);
    wr(4, 24'h0000ff);
    repeat (2) @(posedge clk);
    rd_chk(16'h00c3);
    // Open-drain bits release on a high latch; a read beside the write is refused.
    wr(2, 24'h000030);
    wr(0, 24'h000000);
    @(posedge clk);
    #5 stb[1] = 1'b1;
    wr_change_irq_enable = 24'h0000f0;
    rd_port = 1'b1;
    @(posedge clk);
    #5 stb = 9'h000;
    rd_port = 1'b0;
    chk(rd_valid, 1'b0);
    repeat (2) @(posedge clk);
    chk(pin_oe_n, 16'h0030);
    chk(pin_out, 16'h00c0);
    rd_chk(16'h00c0);
    wr(7, 24'h000000);
    wr(5, 24'h000001);
    wr(6, 24'h800000);
    wr(8, 24'hff0000);
    // The pull-up drive follows its enable word one edge later.
    @(posedge clk);
    #5;
    chk(weak_pullup_on, 24'hff0000);
    chk(change_irq_enable_bit, 24'h800001);
    sleep_mode = 1'b1;
    cn_flip(0, 1'b1);
    cn_flip(0, 1'b1);
    cn_flip(23, 1'b1);
    cn_flip(5, 1'b0);
    finish_test();
  end
endmodule
bind analog_select_bit_port analog_select_bit_port_props u_props (.*);
